// ===== verilog/avpc_pkg.sv
// Package of offsets, field positions, reset values and decode constants
package avpc_pkg;

  // ==========================================================================
  // Register offsets on the control port
  localparam logic [7:0] RIGHT_LEVEL_ADDR   = 8'h05;
  localparam logic [7:0] ANALOG_CTRL_ADDR   = 8'h06;
  localparam logic [7:0] RESERVED_SLOT_ADDR = 8'h07;
  localparam logic [7:0] FAULT_CFG_ADDR     = 8'h08;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RIGHT_LEVEL_RST = 8'hcf;
  localparam logic [7:0] ANALOG_CTRL_RST = 8'h51;
  localparam logic [1:0] OC_THRESH_RST   = 2'h0;

  // ==========================================================================
  // Level decode: half-dB steps, unity code, mute floor
  localparam logic [7:0] LEVEL_TOP_CODE   = 8'hff;
  localparam logic [7:0] LEVEL_FLOOR_CODE = 8'h07;
  localparam logic [8:0] LEVEL_UNITY_CODE = 9'h0cf;

  // ==========================================================================
  // Analog control field positions
  localparam int MUST_ONE_BIT  = 7;
  localparam int RATE_MSB      = 6;
  localparam int RATE_LSB      = 4;
  localparam int AGAIN_MSB     = 3;
  localparam int AGAIN_LSB     = 2;
  localparam int CHAN_PICK_BIT = 1;
  localparam int KEEP_ONE_BIT  = 0;

  // ==========================================================================
  // Fault register field positions
  localparam int OCTH_MSB    = 5;
  localparam int OCTH_LSB    = 4;
  localparam int CLKF_BIT    = 3;
  localparam int OCF_BIT     = 2;
  localparam int DCF_BIT     = 1;
  localparam int OTF_BIT     = 0;

  // ==========================================================================
  // Analog gain in tenths of dBV
  localparam logic [7:0] AGAIN_0_DDBV = 8'hc0;
  localparam logic [7:0] AGAIN_1_DDBV = 8'he2;
  localparam logic [7:0] AGAIN_2_DDBV = 8'hfa;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

endpackage

// ===== verilog/avpc_fault_capture.sv
// Fault flag capture: pin synchronisers, latching and self-clearing flags
module avpc_fault_capture #(
  parameter int LATCH_W = 3
) (
  input  wire logic               clk_i,            // System clock
  input  wire logic               srst_i,           // Synchronous reset
  input  wire logic               ce_i,             // Clock enable
  input  wire logic [LATCH_W-1:0] latch_event_i,    // Raw latching fault pins
  input  wire logic               clock_event_i,    // Raw clock fault pin
  input  wire logic               shutdown_n_i,     // Raw shutdown pin, low = shut
  output logic      [LATCH_W-1:0] latched_o,        // Latched fault flags
  output logic                    clock_fault_o,    // Live clock fault flag
  output logic                    shutdown_o        // Synced shutdown level
);

  // ==========================================================================
  // Two-stage synchronisers
  logic [LATCH_W+1:0] sync_a;
  logic [LATCH_W+1:0] sync_b;
  wire  [LATCH_W-1:0] ev_s   = sync_b[LATCH_W-1:0];
  wire                clk_s  = sync_b[LATCH_W];
  wire                sdn_s  = sync_b[LATCH_W+1];

  // First stage read only by the second stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Shutdown stage rests at its idle high level, so no false shutdown
      sync_a <= {1'b1, {(LATCH_W+1){1'b0}}};
      sync_b <= {1'b1, {(LATCH_W+1){1'b0}}};
    end else if (ce_i) begin
      sync_a <= {shutdown_n_i, clock_event_i, latch_event_i};
      sync_b <= sync_a;
    end
  end

  // Event sets; shutdown clears only where no event is present
  wire [LATCH_W-1:0] next_latched = ev_s | (latched_o & {LATCH_W{sdn_s}});

  // Flag registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latched_o     <= '0;
      clock_fault_o <= 1'b0;
      shutdown_o    <= 1'b0;
    end else if (ce_i) begin
      latched_o     <= next_latched;
      clock_fault_o <= clk_s;
      shutdown_o    <= ~sdn_s;
    end
  end

endmodule

// ===== verilog/avpc_regs.sv
// Volume, switching-rate, analog-control and fault register bank
// Summary of operation
// - Right-level code 0xFF gives +24 dB, 0xFE gives +23.5 dB.
// - Right level resets to 0xCF, which means 0 dB.
// - Right-level code 0x07 gives -100 dB.
// - Codes below 0x07 mute the channel.
// - Bits 6:4 pick switching multiple 6..24 of frame clock; reset 101.
// - In double speed the switching frequency is halved.
// - Speed-range select clear means single speed, set means double speed.
// - Bits 3:2 pick analog gain 19.2, 22.6 or 25 dBV; reset 00.
// - Bit 1 picks right (0) or left (1) source in software mode.
// - Fault register 0x08: reserved 7:6, threshold 5:4, four status flags.
// - Clock fault flag clears itself once clocks are valid again.
// - Other faults latch and halt until shutdown pin is toggled.
module avpc_regs (
  input  wire logic       clk_i,               // 50 MHz system clock
  input  wire logic       srst_i,              // Synchronous reset, high
  input  wire logic       ce_i,                // Clock enable
  input  wire logic       wr_en_i,             // Control port write strobe
  input  wire logic       rd_en_i,             // Control port read strobe
  input  wire logic [7:0] addr_i,              // Control port register address
  input  wire logic [7:0] wdata_i,             // Control port write data
  output logic      [7:0] rdata_o,             // Control port read data
  input  wire logic       speed_range_select_i,// Double speed when high
  input  wire logic       sw_mode_i,           // Software control mode
  input  wire logic       overcurrent_i,       // Raw overcurrent pin
  input  wire logic       offset_i,            // Raw DC offset pin
  input  wire logic       overtemp_i,          // Raw overtemperature pin
  input  wire logic       clock_bad_i,         // Raw clock error pin
  input  wire logic       amplifier_shutdown_pin_n_i, // Shutdown pin, low active
  output logic signed [8:0] gain_half_db_o,    // Channel gain in 0.5 dB units
  output logic            mute_o,              // Channel muted
  output logic      [5:0] switch_half_mult_o,  // Switching rate, half frames
  output logic            double_speed_o,      // Double speed rates accepted
  output logic      [7:0] analog_gain_ddbv_o,  // Analog gain, 0.1 dBV units
  output logic            feed_left_o,         // Amplifier fed from left slot
  output logic      [1:0] oc_threshold_o,      // Overcurrent threshold code
  output logic            amp_halt_o           // Amplifier operation halted
);

  // ==========================================================================
  // Decode functions
  function automatic logic [4:0] rate_mult(input logic [2:0] code);
    case (code)
      3'h0:    rate_mult = 5'h06;
      3'h1:    rate_mult = 5'h08;
      3'h2:    rate_mult = 5'h0a;
      3'h3:    rate_mult = 5'h0c;
      3'h4:    rate_mult = 5'h0e;
      3'h5:    rate_mult = 5'h10;
      3'h6:    rate_mult = 5'h14;
      default: rate_mult = 5'h18;
    endcase
  endfunction

  function automatic logic [7:0] again_ddbv(input logic [1:0] code);
    case (code)
      2'h1:    again_ddbv = avpc_pkg::AGAIN_1_DDBV;
      2'h2:    again_ddbv = avpc_pkg::AGAIN_2_DDBV;
      default: again_ddbv = avpc_pkg::AGAIN_0_DDBV;
    endcase
  endfunction

  // ==========================================================================
  // Register storage
  logic [7:0] right_level;
  logic [7:0] analog_control;
  logic [1:0] oc_thresh;

  wire wr_level  = wr_en_i && (addr_i == avpc_pkg::RIGHT_LEVEL_ADDR);
  wire wr_analog = wr_en_i && (addr_i == avpc_pkg::ANALOG_CTRL_ADDR);
  wire wr_fault  = wr_en_i && (addr_i == avpc_pkg::FAULT_CFG_ADDR);

  // Writable registers; reserved slot and read-only bits ignore writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      right_level    <= avpc_pkg::RIGHT_LEVEL_RST;
      analog_control <= avpc_pkg::ANALOG_CTRL_RST;
      oc_thresh      <= avpc_pkg::OC_THRESH_RST;
    end else if (ce_i) begin
      if (wr_level) right_level <= wdata_i;
      if (wr_analog) analog_control <= wdata_i;
      if (wr_fault) oc_thresh <= wdata_i[avpc_pkg::OCTH_MSB:avpc_pkg::OCTH_LSB];
    end
  end

  // ==========================================================================
  // Fault capture
  logic [2:0] latched;
  logic       clock_fault;
  logic       shut_down;

  avpc_fault_capture #(
    .LATCH_W (3)
  ) u_fault (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .ce_i          (ce_i),
    .latch_event_i ({overcurrent_i, offset_i, overtemp_i}),
    .clock_event_i (clock_bad_i),
    .shutdown_n_i  (amplifier_shutdown_pin_n_i),
    .latched_o     (latched),
    .clock_fault_o (clock_fault),
    .shutdown_o    (shut_down)
  );

  // ==========================================================================
  // Next-value decode
  wire [2:0] rate_code  = analog_control[avpc_pkg::RATE_MSB:avpc_pkg::RATE_LSB];
  wire [1:0] again_code = analog_control[avpc_pkg::AGAIN_MSB:avpc_pkg::AGAIN_LSB];
  wire [4:0] mult       = rate_mult(rate_code);
  wire [5:0] next_rate  = speed_range_select_i ? {1'b0, mult}
                                               : {mult, 1'b0};
  wire signed [8:0] next_gain = $signed({1'b0, right_level})
                              - $signed(avpc_pkg::LEVEL_UNITY_CODE);
  wire next_mute = right_level < avpc_pkg::LEVEL_FLOOR_CODE;
  wire next_left = sw_mode_i && analog_control[avpc_pkg::CHAN_PICK_BIT];
  wire next_halt = (|latched) || clock_fault || shut_down;
  wire [7:0] fault_view = {2'h0, oc_thresh, clock_fault, latched};

  // Read mux; reserved and unmapped addresses read zero
  wire [7:0] next_rdata =
    (addr_i == avpc_pkg::RIGHT_LEVEL_ADDR) ? right_level    :
    (addr_i == avpc_pkg::ANALOG_CTRL_ADDR) ? analog_control :
    (addr_i == avpc_pkg::FAULT_CFG_ADDR)   ? fault_view     : 8'h00;

  // ==========================================================================
  // Output registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o            <= 8'h00;
      gain_half_db_o     <= 9'sh000;
      mute_o             <= 1'b0;
      switch_half_mult_o <= 6'h20;
      double_speed_o     <= 1'b0;
      analog_gain_ddbv_o <= avpc_pkg::AGAIN_0_DDBV;
      feed_left_o        <= 1'b0;
      oc_threshold_o     <= avpc_pkg::OC_THRESH_RST;
      amp_halt_o         <= 1'b0;
    end else if (ce_i) begin
      if (rd_en_i) rdata_o <= next_rdata;
      gain_half_db_o     <= next_gain;
      mute_o             <= next_mute;
      switch_half_mult_o <= next_rate;
      double_speed_o     <= speed_range_select_i;
      analog_gain_ddbv_o <= again_ddbv(again_code);
      feed_left_o        <= next_left;
      oc_threshold_o     <= oc_thresh;
      amp_halt_o         <= next_halt;
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_level_write;
    ce_i && wr_level;
  endsequence

  property p_top_gain;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && right_level == 8'hff) |=> (gain_half_db_o == 9'sd48);
  endproperty
  a_top_gain: assert property (p_top_gain) else $error("Top code gain wrong");

  property p_step_gain;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && right_level == 8'hfe) |=> (gain_half_db_o == 9'sd47);
  endproperty
  a_step_gain: assert property (p_step_gain) else $error("Step gain wrong");

  property p_reset_level;
    @(posedge clk_i) disable iff (srst_i)
    ($fell(srst_i) && $past(ce_i)) |->
      (right_level == 8'hcf) ##1 ce_i [*1] |=> gain_half_db_o == 9'sd0;
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("Reset level wrong");

  property p_floor_gain;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && right_level == 8'h07) |=> (gain_half_db_o == -9'sd200 && !mute_o);
  endproperty
  a_floor_gain: assert property (p_floor_gain) else $error("Floor gain wrong");

  property p_mute;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && right_level < 8'h07) |=> mute_o;
  endproperty
  a_mute: assert property (p_mute) else $error("Mute missing");

  property p_level_write;
    @(posedge clk_i) disable iff (srst_i)
    s_level_write |=> (right_level == $past(wdata_i));
  endproperty
  a_level_write: assert property (p_level_write) else $error("Level write lost");

  property p_rate;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && rate_code == 3'h5) |=>
      (switch_half_mult_o == ($past(speed_range_select_i) ? 6'h10 : 6'h20));
  endproperty
  a_rate: assert property (p_rate) else $error("Switching rate wrong");

  property p_again;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && again_code == 2'h1) |=> (analog_gain_ddbv_o == 8'he2);
  endproperty
  a_again: assert property (p_again) else $error("Analog gain wrong");

  property p_chan;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && sw_mode_i) |=> (feed_left_o == $past(analog_control[1]));
  endproperty
  a_chan: assert property (p_chan) else $error("Channel pick wrong");

  property p_latch_hold;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && latched[2]) |=> (latched[2] || shut_down);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Fault dropped");

  property p_halt;
    @(posedge clk_i) disable iff (srst_i)
    (ce_i && (|latched || clock_fault)) |=> amp_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt missing");

endmodule

// ===== verif/avpc_tb.sv
// Self-checking bench for the volume, switching-rate and fault register bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

  // ==========================================================================
  // Stimulus and observed signals
  logic              clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              ce_i = 1'b1;
  logic              wr_en_i = 1'b0;
  logic              rd_en_i = 1'b0;
  logic        [7:0] addr_i = 8'h00;
  logic        [7:0] wdata_i = 8'h00;
  logic        [7:0] rdata_o;
  logic              speed_i = 1'b0;
  logic              sw_mode_i = 1'b0;
  logic        [2:0] lat_pins = 3'h0;
  logic              clock_bad_i = 1'b0;
  logic              shut_n_i = 1'b1;
  logic signed [8:0] gain_half_db_o;
  logic              mute_o;
  logic        [5:0] switch_half_mult_o;
  logic              double_speed_o;
  logic        [7:0] analog_gain_ddbv_o;
  logic              feed_left_o;
  logic        [1:0] oc_threshold_o;
  logic              amp_halt_o;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                mult [8] = '{6, 8, 10, 12, 14, 16, 20, 24};
  logic        [7:0] gains [3] = '{8'hc0, 8'he2, 8'hfa};

  // Clock at 50 MHz
  always #10 clk_i = ~clk_i;

  // Device under test
  avpc_regs i_avpc_regs (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .speed_range_select_i(speed_i), .sw_mode_i(sw_mode_i),
    .overcurrent_i(lat_pins[2]), .offset_i(lat_pins[1]), .overtemp_i(lat_pins[0]),
    .clock_bad_i(clock_bad_i), .amplifier_shutdown_pin_n_i(shut_n_i),
    .gain_half_db_o(gain_half_db_o), .mute_o(mute_o),
    .switch_half_mult_o(switch_half_mult_o), .double_speed_o(double_speed_o),
    .analog_gain_ddbv_o(analog_gain_ddbv_o), .feed_left_o(feed_left_o),
    .oc_threshold_o(oc_threshold_o), .amp_halt_o(amp_halt_o)
  );

  // ==========================================================================
  // Bus cycles and pacing
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i);
    #1 wr_en_i = 1'b0;
    idle(3);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1 rd_en_i = 1'b1;
    addr_i = a;
    @(posedge clk_i);
    #1 rd_en_i = 1'b0;
    d = rdata_o;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    rd(8'h05, d); `CHK("level reset", 8'hcf, d)
    rd(8'h06, d); `CHK("analog reset", 8'h51, d)
    rd(8'h08, d); `CHK("fault reset", 8'h00, d)
    `CHK("gain reset", 9'h000, gain_half_db_o)
    `CHK("rate reset", 6'h20, switch_half_mult_o)
    `CHK("again reset", 8'hc0, analog_gain_ddbv_o)
    `CHK("left reset", 1'b0, feed_left_o)
    `CHK("halt reset", 1'b0, amp_halt_o)
  endtask

  task automatic t_level();
    wr(8'h05, 8'hff); `CHK("gain top", 9'h030, gain_half_db_o)
    wr(8'h05, 8'hfe); `CHK("gain step", 9'h02f, gain_half_db_o)
    wr(8'h05, 8'h08); `CHK("gain low", 9'h139, gain_half_db_o)
    `CHK("mute low", 1'b0, mute_o)
    wr(8'h05, 8'h07); `CHK("gain floor", 9'h138, gain_half_db_o)
    `CHK("mute floor", 1'b0, mute_o)
    wr(8'h05, 8'h06); `CHK("mute below", 1'b1, mute_o)
    wr(8'h05, 8'h00); `CHK("mute zero", 1'b1, mute_o)
  endtask

  // Bit 7 written as one, bit 0 kept at one, gain code 11 never written
  task automatic t_analog();
    for (int s = 0; s < 2; s++) begin
      speed_i = s[0];
      for (int c = 0; c < 8; c++) begin
        wr(8'h06, 8'h81 | (c[7:0] << 4));
        `CHK("rate", 6'(mult[c] * (2 - s)), switch_half_mult_o)
        `CHK("speed", s[0], double_speed_o)
      end
    end
    for (int g = 0; g < 3; g++) begin
      wr(8'h06, 8'hd1 | (g[7:0] << 2));
      `CHK("again", gains[g], analog_gain_ddbv_o)
    end
    wr(8'h06, 8'hd3); `CHK("left hw mode", 1'b0, feed_left_o)
    sw_mode_i = 1'b1;
    idle(3); `CHK("left sw mode", 1'b1, feed_left_o)
    wr(8'h06, 8'hd1); `CHK("right sw mode", 1'b0, feed_left_o)
  endtask

  task automatic t_map();
    logic [7:0] d;
    // Reserved slot 0x07 is never touched; unmapped bytes stand in for it
    wr(8'h40, 8'hff);
    rd(8'h40, d); `CHK("unmapped write", 8'h00, d)
    rd(8'h20, d); `CHK("unmapped", 8'h00, d)
    // Write with clock enable low must not land
    ce_i = 1'b0;
    wr(8'h05, 8'h55);
    ce_i = 1'b1;
    rd(8'h05, d); `CHK("frozen level", 8'h00, d)
    wr(8'h08, 8'hff);
    rd(8'h08, d); `CHK("fault write", 8'h30, d)
    `CHK("oc threshold", 2'h3, oc_threshold_o)
  endtask

  task automatic t_fault();
    logic [7:0] d;
    clock_bad_i = 1'b1;
    idle(6);
    rd(8'h08, d); `CHK("clock flag", 8'h38, d)
    clock_bad_i = 1'b0;
    idle(6);
    rd(8'h08, d); `CHK("clock clear", 8'h30, d)
    for (int i = 0; i < 3; i++) begin
      lat_pins = 3'(1 << i);
      idle(2);
      lat_pins = 3'h0;
      idle(6);
      rd(8'h08, d); `CHK("latched flag", 8'h30 | 8'(1 << i), d)
      `CHK("halt", 1'b1, amp_halt_o)
      shut_n_i = 1'b0;
      idle(6); `CHK("halt shut", 1'b1, amp_halt_o)
      shut_n_i = 1'b1;
      idle(6);
      rd(8'h08, d); `CHK("flag cleared", 8'h30, d)
      `CHK("resume", 1'b0, amp_halt_o)
    end
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 270 cycles
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    #1 srst_i = 1'b0;
    idle(3);
    t_reset();
    t_level();
    t_analog();
    t_map();
    t_fault();
    complete_run();
  end
endmodule
